// ==== verilog/fab_pkg.sv ====
// constants, carriers and state layout for the file alu / bit skip executor
// assumes one instruction clock shared with the fetch pipeline and the bus master
//
// Functional notes
// [RULE_01] the add-accumulator-to-file opcode 0111 with a destination bit sums accumulator and file register and updates overflow, half-byte and null flags.
// [RULE_02] with destination bit 0 the result goes to the accumulator, with 1 back into the addressed file register.
// [RULE_03] the and opcode 00 0101 ands accumulator with the addressed register and changes only the null flag.
// [RULE_04] the file register address is the low seven bits of the word and spans 0 to 127.
// [RULE_05] the bit-clear opcode forces only the indexed bit of the register to zero and leaves every flag alone.
// [RULE_06] the bit-test-skip-if-clear opcode skips the next instruction when the indexed bit is 0, changing no flag.
// [RULE_07] on a skip the prefetched instruction is discarded and an idle slot runs instead, two cycles against one.
// [RULE_08] the skip-if-clear opcode is recognised by leading bits 01 10, then a three-bit index and a seven-bit address.
// [RULE_09] overflow is the carry out of bit 7, half-byte the carry out of bit 3, null set when the 8-bit add or and result is zero.

package fab_pkg;

    // ------------------------------------------------------------------
    // widths and instruction fields
    // ------------------------------------------------------------------
    localparam int unsigned FAB_WORD_W = 14;
    localparam int unsigned FAB_DATA_W = 8;
    localparam int unsigned FAB_ADDR_W = 7;
    localparam int unsigned FAB_FILE_DEPTH = 128;
    localparam int unsigned FAB_BUS_ADDR_W = 8;
    localparam int unsigned FAB_BYTE_OP_MSB = 13;
    localparam int unsigned FAB_BYTE_OP_LSB = 8;
    localparam int unsigned FAB_BIT_OP_LSB = 10;
    localparam int unsigned FAB_DEST_POS = 7;
    localparam int unsigned FAB_BIDX_MSB = 9;
    localparam int unsigned FAB_BIDX_LSB = 7;
    localparam int unsigned FAB_NIBBLE_W = 4;

    // ------------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------------
    localparam logic [5:0] FAB_OP_ADD_ACC_TO_FILE = 6'h07;
    localparam logic [5:0] FAB_OP_AND_ACC_WITH_FILE = 6'h05;
    localparam logic [3:0] FAB_OP_FILE_BIT_CLEAR = 4'h4;
    localparam logic [3:0] FAB_OP_SKIP_IF_BIT_LOW = 4'h6;
    localparam logic FAB_DEST_ACC = 1'b0;

    // ------------------------------------------------------------------
    // register port map: 0x00..0x7f are file registers
    // ------------------------------------------------------------------
    localparam logic [7:0] FAB_REG_FILE_LAST = 8'h7f;
    localparam logic [7:0] FAB_REG_ACC = 8'h80;
    localparam logic [7:0] FAB_REG_STATUS = 8'h81;
    localparam logic [7:0] FAB_REG_CTRL = 8'h82;
    localparam int unsigned FAB_CTRL_RUN_POS = 0;
    localparam logic FAB_CTRL_RUN_RST = 1'b1;
    localparam logic [7:0] FAB_ACC_RST = 8'h00;
    localparam logic [7:0] FAB_ZERO_BYTE = 8'h00;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [FAB_WORD_W-1:0] word;
    } fab_instr_t;

    typedef struct packed {
        logic [FAB_BUS_ADDR_W-1:0] addr;
        logic [FAB_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } fab_bus_t;

    // bit 2 overflow, bit 1 half-byte, bit 0 null as seen on the status register
    typedef struct packed {
        logic overflow_out_flag;
        logic half_byte_overflow_flag;
        logic result_null_flag;
    } fab_flags_t;

    typedef enum logic {
        FAB_PH_EXEC,
        FAB_PH_IDLE
    } fab_phase_t;

    typedef struct packed {
        logic [FAB_FILE_DEPTH-1:0][FAB_DATA_W-1:0] file_mem;
        logic [FAB_DATA_W-1:0] acc;
        fab_flags_t flags;
        logic run_enable;
        fab_phase_t phase;
        logic [FAB_DATA_W-1:0] rd_data;
        logic skip_discard;
        logic idle_slot;
        logic exec_done;
    } fab_state_t;

endpackage

// ==== verilog/fab_core.sv ====
// executor for add / and with file, file bit clear and bit test skip if clear
// assumes the fetch pipeline presents one word per clock and keeps moving; the core drops the word behind a skip itself;
// bus strobes are one cycle, never together, synchronous to clk
`timescale 1ns/100ps
`default_nettype none

module fab_core (
    input wire logic clk,
    input wire logic rst_n,
    input wire fab_pkg::fab_instr_t instr,
    input wire fab_pkg::fab_bus_t bus,
    output logic [7:0] rd_data,
    output logic [7:0] acc_out,
    output fab_pkg::fab_flags_t flags_out,
    output logic skip_discard,
    output logic idle_slot,
    output logic exec_done
);

    // ------------------------------------------------------------------
    // state and operand decode
    // ------------------------------------------------------------------
    fab_pkg::fab_state_t st;
    fab_pkg::fab_state_t next_st;

    logic [fab_pkg::FAB_ADDR_W-1:0] f_addr;
    logic [2:0] bit_idx;
    logic dest_sel;
    logic [5:0] byte_op;
    logic [3:0] bit_op;
    logic [7:0] f_val;
    logic [8:0] sum9;
    logic [4:0] sum_lo;
    logic [7:0] and_res;
    logic [7:0] clr_mask;

    // address is the low seven bits, so 0..127 only
    assign f_addr = instr.word[fab_pkg::FAB_ADDR_W-1:0]; // RULE_04
    assign bit_idx = instr.word[fab_pkg::FAB_BIDX_MSB:fab_pkg::FAB_BIDX_LSB];
    assign dest_sel = instr.word[fab_pkg::FAB_DEST_POS];
    assign byte_op = instr.word[fab_pkg::FAB_BYTE_OP_MSB:fab_pkg::FAB_BYTE_OP_LSB];
    assign bit_op = instr.word[fab_pkg::FAB_BYTE_OP_MSB:fab_pkg::FAB_BIT_OP_LSB];
    assign f_val = st.file_mem[f_addr];

    // ------------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------------
    // nine and five bit sums expose the carries out of bit 7 and bit 3
    assign sum9 = {1'b0, st.acc} + {1'b0, f_val}; // RULE_01
    assign sum_lo = {1'b0, st.acc[fab_pkg::FAB_NIBBLE_W-1:0]}
                  + {1'b0, f_val[fab_pkg::FAB_NIBBLE_W-1:0]};
    assign and_res = st.acc & f_val; // RULE_03
    assign clr_mask = ~(8'h01 << bit_idx); // RULE_05

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.rd_data = fab_pkg::FAB_ZERO_BYTE;
        next_st.skip_discard = 1'b0;
        next_st.idle_slot = 1'b0;
        next_st.exec_done = 1'b0;

        // register port read, data stands the next cycle only
        if (bus.rd) begin
            if (bus.addr <= fab_pkg::FAB_REG_FILE_LAST) begin
                next_st.rd_data = st.file_mem[bus.addr[fab_pkg::FAB_ADDR_W-1:0]];
            end else if (bus.addr == fab_pkg::FAB_REG_ACC) begin
                next_st.rd_data = st.acc;
            end else if (bus.addr == fab_pkg::FAB_REG_STATUS) begin
                next_st.rd_data = {5'h00, st.flags};
            end else if (bus.addr == fab_pkg::FAB_REG_CTRL) begin
                next_st.rd_data = {7'h00, st.run_enable};
            end
        end

        // register port write; an instruction in the same cycle overrides it
        if (bus.wr) begin
            if (bus.addr <= fab_pkg::FAB_REG_FILE_LAST) begin
                next_st.file_mem[bus.addr[fab_pkg::FAB_ADDR_W-1:0]] = bus.wdata;
            end else if (bus.addr == fab_pkg::FAB_REG_ACC) begin
                next_st.acc = bus.wdata;
            end else if (bus.addr == fab_pkg::FAB_REG_STATUS) begin
                next_st.flags = bus.wdata[2:0];
            end else if (bus.addr == fab_pkg::FAB_REG_CTRL) begin
                next_st.run_enable = bus.wdata[fab_pkg::FAB_CTRL_RUN_POS];
            end
        end

        unique case (st.phase)
            // the word presented now was prefetched behind a taken skip
            fab_pkg::FAB_PH_IDLE: begin
                next_st.idle_slot = 1'b1; // RULE_07
                next_st.phase = fab_pkg::FAB_PH_EXEC;
            end
            fab_pkg::FAB_PH_EXEC: begin
                if (instr.valid && st.run_enable) begin
                    next_st.exec_done = 1'b1;
                    if (byte_op == fab_pkg::FAB_OP_ADD_ACC_TO_FILE) begin
                        // RULE_01
                        next_st.flags.overflow_out_flag = sum9[8]; // RULE_09
                        next_st.flags.half_byte_overflow_flag = sum_lo[4]; // RULE_09
                        next_st.flags.result_null_flag =
                            (sum9[7:0] == fab_pkg::FAB_ZERO_BYTE); // RULE_09
                        if (dest_sel == fab_pkg::FAB_DEST_ACC) begin
                            next_st.acc = sum9[7:0]; // RULE_02
                        end else begin
                            next_st.file_mem[f_addr] = sum9[7:0]; // RULE_02
                        end
                    end else if (byte_op == fab_pkg::FAB_OP_AND_ACC_WITH_FILE) begin
                        // only the null flag moves on an and
                        next_st.flags.result_null_flag =
                            (and_res == fab_pkg::FAB_ZERO_BYTE); // RULE_03
                        if (dest_sel == fab_pkg::FAB_DEST_ACC) begin
                            next_st.acc = and_res; // RULE_02
                        end else begin
                            next_st.file_mem[f_addr] = and_res; // RULE_02
                        end
                    end else if (bit_op == fab_pkg::FAB_OP_FILE_BIT_CLEAR) begin
                        next_st.file_mem[f_addr] = f_val & clr_mask; // RULE_05
                    end else if (bit_op == fab_pkg::FAB_OP_SKIP_IF_BIT_LOW) begin // RULE_08
                        // flags untouched; a low bit costs one extra cycle
                        if (!f_val[bit_idx]) begin // RULE_06
                            next_st.skip_discard = 1'b1; // RULE_07
                            next_st.phase = fab_pkg::FAB_PH_IDLE; // RULE_07
                        end
                    end else begin
                        // opcodes of other units are not ours to execute
                        next_st.exec_done = 1'b0;
                    end
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.acc <= fab_pkg::FAB_ACC_RST;
            st.run_enable <= fab_pkg::FAB_CTRL_RUN_RST;
            st.phase <= fab_pkg::FAB_PH_EXEC;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all straight from the state register
    // ------------------------------------------------------------------
    assign rd_data = st.rd_data;
    assign acc_out = st.acc;
    assign flags_out = st.flags;
    assign skip_discard = st.skip_discard;
    assign idle_slot = st.idle_slot;
    assign exec_done = st.exec_done;

endmodule

`default_nettype wire

// ==== sim/fab_core_sva.sv ====
// checker for the file alu / bit skip executor
// assumes only the fab_core ports; bound at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module fab_core_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire fab_pkg::fab_instr_t instr,
    input wire fab_pkg::fab_bus_t bus,
    input wire logic [7:0] rd_data,
    input wire logic [7:0] acc_out,
    input wire fab_pkg::fab_flags_t flags_out,
    input wire logic skip_discard,
    input wire logic idle_slot,
    input wire logic exec_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // a word counts only when it is not the discarded one
    wire logic tk = instr.valid && !skip_discard;
    wire logic [5:0] op = instr.word[13:8];
    wire logic [3:0] bop = instr.word[13:10];
    wire logic byt = tk && (op == 6'h05 || op == 6'h07);
    sequence s_skip_tail;
        exec_done ##1 (idle_slot && !exec_done);
    endsequence
    AST_SKIP_STEPS: assert property (skip_discard |-> s_skip_tail)
        else $error("skip steps wrong");
    AST_IDLE_CAUSE: assert property (idle_slot |-> $past(skip_discard))
        else $error("idle slot without discard");
    AST_DISCARD_QUIET: assert property (skip_discard |=> $stable(acc_out) && $stable(flags_out))
        else $error("discarded word had effect");
    AST_SKIP_SOURCE: assert property (skip_discard |-> $past(tk && bop == 4'h6))
        else $error("discard not caused by skip test");
    AST_SKIP_FLAGS: assert property (tk && bop == 4'h6 |=> exec_done && $stable(flags_out))
        else $error("skip test changed flags");
    AST_CLEAR_QUIET: assert property (tk && bop == 4'h4 |=> exec_done && $stable(flags_out))
        else $error("bit clear changed flags");
    AST_AND_FLAGS: assert property (tk && op == 6'h05 |=> flags_out[2:1] == $past(flags_out[2:1]))
        else $error("and touched carry flags");
    AST_DEST_FILE: assert property (byt && instr.word[7] |=> exec_done && $stable(acc_out))
        else $error("file destination changed acc");
    AST_NULL_ACC: assert property (byt && !instr.word[7] |=> flags_out[0] == (acc_out == 8'h00))
        else $error("null flag wrong");
endmodule
bind fab_core fab_core_sva chk (.clk, .rst_n, .instr, .bus, .rd_data, .acc_out, .flags_out,
    .skip_discard, .idle_slot, .exec_done);
`default_nettype wire

// ==== sim/fab_fetch_model.sv ====
// fetch pipeline model: four words, one per clock, after a go pulse
// assumes the core discards by itself; the pipeline just moves on
`timescale 1ns/100ps
`default_nettype none
module fab_fetch_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [3:0][13:0] prog,
    output var fab_pkg::fab_instr_t instr
);
    logic [2:0] pc;
    logic tog;
    // word line toggles when idle so a stale word never looks valid
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc <= 3'd4;
            tog <= 1'b0;
        end else begin
            tog <= !tog;
            pc <= go ? 3'd0 : (pc == 3'd4 ? pc : pc + 3'd1);
        end
    end
    always_comb begin
        instr.valid = (pc != 3'd4);
        instr.word = instr.valid ? prog[pc[1:0]] : {7{tog, !tog}};
    end
endmodule
`default_nettype wire

// ==== sim/tb_file_alu_bit_skip_ops.sv ====
// self-checking bench for the file alu / bit skip executor
// assumes fab_core, the fetch model and the bound checker
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("Error %s exp %h got %h", nm, e, g); end end
module tb_file_alu_bit_skip_ops;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic go = 1'b0;
    logic [3:0][13:0] prog = '0;
    fab_pkg::fab_bus_t bus = '0;
    fab_pkg::fab_instr_t instr;
    fab_pkg::fab_flags_t flags_out;
    logic [7:0] rd_data;
    logic [7:0] acc_out;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    always #12.5 clk = ~clk;
    fab_fetch_model fetch (.clk, .rst_n, .go, .prog, .instr);
    fab_core uut (.clk, .rst_n, .instr, .bus, .rd_data, .acc_out, .flags_out,
        .skip_discard(), .idle_slot(), .exec_done());
    function automatic logic [13:0] byt(logic [5:0] o, logic d, logic [6:0] a);
        return {o, d, a};
    endfunction
    function automatic logic [13:0] bit_op(logic [3:0] o, logic [2:0] b, logic [6:0] a);
        return {o, b, a};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        @(negedge clk);
        `CHK(nm, e, rd_data)
    endtask
    // pad words carry an unused opcode, so they must do nothing
    task automatic run(input logic [13:0] w0, input logic [13:0] w1, input logic [13:0] w2);
        @(posedge clk);
        prog <= {14'h3000, w2, w1, w0};
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic t_add();
        wr(8'h05, 8'h0f);
        wr(8'h80, 8'h01);
        run(byt(6'h07, 1'b0, 7'h05), 14'h3000, 14'h3000);
        `CHK("add acc", 8'h10, acc_out)
        `CHK("add flags", 3'b010, flags_out)
        wr(8'h80, 8'hf1);
        run(byt(6'h07, 1'b1, 7'h05), 14'h3000, 14'h3000);
        rd(8'h05, 8'h00, "add file");
        `CHK("add carry", 3'b111, flags_out)
        `CHK("add keep", 8'hf1, acc_out)
    endtask
    task automatic t_and();
        wr(8'h7f, 8'h3c);
        wr(8'h80, 8'hc3);
        run(byt(6'h05, 1'b0, 7'h7f), 14'h3000, 14'h3000);
        `CHK("and acc", 8'h00, acc_out)
        rd(8'h81, 8'h07, "and status");
        rd(8'h90, 8'h00, "unmapped");
    endtask
    task automatic t_clr();
        for (int b = 0; b < 8; b++) begin
            wr(8'h03, 8'hff);
            run(bit_op(4'h4, 3'(b), 7'h03), 14'h3000, 14'h3000);
            rd(8'h03, ~(8'h01 << b), "clear bit");
            `CHK("clear flags", 3'b111, flags_out)
        end
    endtask
    task automatic t_skip();
        wr(8'h02, 8'h02);
        wr(8'h80, 8'h00);
        run(bit_op(4'h6, 3'd0, 7'h02), byt(6'h07, 1'b0, 7'h02), byt(6'h07, 1'b0, 7'h02));
        `CHK("skip taken", 8'h02, acc_out)
        wr(8'h80, 8'h00);
        run(bit_op(4'h6, 3'd1, 7'h02), byt(6'h07, 1'b0, 7'h02), byt(6'h07, 1'b0, 7'h02));
        `CHK("no skip", 8'h04, acc_out)
    endtask
    task automatic close_out();
        if (n_fail == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // hang guard well above the roughly 170 cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_add();
        t_and();
        t_clr();
        t_skip();
        close_out();
    end
endmodule
`default_nettype wire
